// file: bvc_consts.vh
`ifndef BVC_CONSTS_VH
`define BVC_CONSTS_VH
// Register subaddresses on the serial register port.
`define BVC_ADDR_BUCK2      8'h17
`define BVC_ADDR_BUCK3      8'h18
`define BVC_ADDR_GO         8'h1A
// Reset values.
`define BVC_RST_BUCK2       8'h99
`define BVC_RST_BUCK3       8'h8C
`define BVC_RST_BUCK3_ALT   8'h8C
`define BVC_RST_CODE2       6'h19
`define BVC_RST_CODE3       6'h0C
`define BVC_RST_GO          8'h00
`define BVC_GO_KEEP_MASK    8'h01
// Field positions.
`define BVC_PSKIP_BIT       7
`define BVC_RSVD_BIT        6
`define BVC_CODE_MSB        5
`define BVC_GO_BIT          7
`define BVC_VOLTAGE_CHANGE_GO_DISABLE_BIT      0
`define BVC_RSVD_MASK       8'hBF
// Blanking time in microseconds and the clock rate in MHz.
`define BVC_BLANK_US        5000
`define BVC_CLK_MHZ         250
`define BVC_BLANK_CYC       (`BVC_BLANK_US * `BVC_CLK_MHZ)
`define BVC_CNT_W           21
`endif

// file: bvc_blank_timer.v
`timescale 1ns/1ps
`include "bvc_consts.vh"
module bvc_blank_timer #(
    parameter [20:0] BLANK_CYC = `BVC_BLANK_CYC
) (
    // Clock and reset.
    input  wire        core_clk,
    input  wire        rst,
    // Restart strobe and blanking state.
    input  wire        restart,
    output reg         blank_q
);
    reg [`BVC_CNT_W-1:0] cnt_q;

    // A write restarts the full interval; blanking holds while the count runs.
    always @(posedge core_clk) begin
        if (rst) begin
            cnt_q   <= {`BVC_CNT_W{1'b0}};
            blank_q <= 1'b0;
        end else if (restart) begin
            cnt_q   <= BLANK_CYC - 21'h00_0001;
            blank_q <= 1'b1;
        end else if (cnt_q != {`BVC_CNT_W{1'b0}}) begin
            cnt_q   <= cnt_q - 21'h00_0001;
            blank_q <= 1'b1;
        end else begin
            blank_q <= 1'b0;
        end
    end
endmodule // bvc_blank_timer

// file: bvc_regs.v
`timescale 1ns/1ps
`include "bvc_consts.vh"
module bvc_regs #(
    parameter [20:0] BLANK_CYC = `BVC_BLANK_CYC
) (
    // Clock and reset.
    input  wire        core_clk,
    input  wire        rst,
    // Register port from the serial interface.
    input  wire        reg_wr,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    output wire        reg_wr_refused,
    // Protection unlock from the password logic.
    input  wire        unlock_ok,
    // Default-select resistor level, sampled after reset.
    input  wire        default_select_resistor,
    // Raw monitor results from buck3.
    input  wire        buck3_ov_raw,
    input  wire        buck3_uv_raw,
    // Converter controls.
    output reg  [5:0]  buck2_voltage_code,
    output reg  [5:0]  buck3_voltage_code,
    output wire        buck2_pulse_skip_enable,
    output wire        buck3_pulse_skip_enable,
    output wire        buck3_forced_pwm,
    output wire        buck3_ov_flag,
    output wire        buck3_uv_flag,
    output wire        buck3_blanking,
    output wire        voltage_change_go_disable
);
    reg  [7:0] buck2_q;
    reg  [7:0] buck3_q;
    reg  [7:0] go_q;
    reg        strap_done_q;
    wire       wr_b2;
    wire       wr_b3;
    wire       wr_go;
    wire       protected_hit;
    wire       apply;

    // Register map seen on the serial register port.
    //
    // Subaddress 0x17 holds the buck2 control byte.
    // Subaddress 0x18 holds the buck3 control byte.
    // Subaddress 0x1A holds the commit byte for voltage changes.
    // Any other subaddress reads back as zero and ignores writes.
    //
    // Layout of both buck control bytes.
    // Bit 7 is the pulse-skip enable; a zero in the buck3 byte also raises buck3_forced_pwm.
    // Bit 6 is reserved: it is never stored, so it always reads zero.
    // Bits 5 to 0 hold the requested output voltage code.
    //
    // Buck2 codes start at 0.850 V and climb 10 mV per step up to 32h.
    // Above 32h the step grows to 25 mV, so 3Fh gives 1.675 V.
    // Buck3 codes start at 0.900 V and climb 25 mV per step up to 1Ah.
    // Above 1Ah the step grows to 50 mV, so 3Fh gives 3.400 V.
    // The decoding of a code into a voltage lives in the analog part;
    // this block only holds and forwards the six-bit codes.
    //
    // Layout of the commit byte.
    // Bit 7 is the go request; it is acted on at the write and not kept.
    // Bit 0 is go-disable; while it is set, new codes pass straight on.
    // All other bits are dropped on write and read back as zero.
    //
    // Write protection.
    // Both buck bytes are guarded by the unlock level from the password
    // logic. A guarded write made while that level is low is dropped and
    // the refusal strobe rises in the same cycle, so the serial front end
    // can report a failed access to the host.
    //
    // Monitoring blanking.
    // Each accepted buck3 write restarts a blanking interval of BLANK_CYC
    // clocks. While it runs, the raw over- and under-voltage results of
    // buck3 are masked, because a step in the set point would otherwise
    // trip the window comparators before the output has settled. A second
    // write during the interval restarts it from the full length.
    //
    // Power-up default.
    // On the first clock after reset the buck3 byte is reloaded from the
    // default-select resistor level. Both choices are constants in the
    // header, so a board variant only needs a new constant.
    //
    // Timing.
    // Writes land on the edge that samples the write strobe. Read data is
    // registered and follows the subaddress one edge later. Applied codes
    // follow the stored bytes one edge after the commit condition.

    // True when a subaddress selects the given register.
    function bvc_hit;
        input [7:0] a;
        input [7:0] target;
        begin
            bvc_hit = (a == target);
        end
    endfunction

    // Clear reserved bit before storage.
    function [7:0] bvc_clean;
        input [7:0] v;
        begin
            bvc_clean = v & `BVC_RSVD_MASK;
        end
    endfunction

    // Write decode; guarded registers need the unlock level.
    assign protected_hit  = reg_wr && (bvc_hit(reg_addr, `BVC_ADDR_BUCK2) ||
                                       bvc_hit(reg_addr, `BVC_ADDR_BUCK3));
    assign reg_wr_refused = protected_hit && !unlock_ok;
    assign wr_b2 = reg_wr && unlock_ok && bvc_hit(reg_addr, `BVC_ADDR_BUCK2);
    assign wr_b3 = reg_wr && unlock_ok && bvc_hit(reg_addr, `BVC_ADDR_BUCK3);
    assign wr_go = reg_wr && bvc_hit(reg_addr, `BVC_ADDR_GO);
    // A go request commits once; a stored go-disable lets codes pass on.
    assign apply = (wr_go && (reg_wdata[`BVC_GO_BIT] ||
                              reg_wdata[`BVC_VOLTAGE_CHANGE_GO_DISABLE_BIT])) ||
                   voltage_change_go_disable;
    assign voltage_change_go_disable = go_q[`BVC_VOLTAGE_CHANGE_GO_DISABLE_BIT];

    // Register storage; buck3 default is re-chosen once after reset from the strap.
    always @(posedge core_clk) begin
        if (rst) begin
            buck2_q      <= `BVC_RST_BUCK2;
            buck3_q      <= `BVC_RST_BUCK3;
            go_q         <= `BVC_RST_GO;
            strap_done_q <= 1'b0;
        end else begin
            strap_done_q <= 1'b1;
            if (!strap_done_q) begin
                buck3_q <= default_select_resistor ? `BVC_RST_BUCK3_ALT
                                                   : `BVC_RST_BUCK3;
            end else if (wr_b3) begin
                buck3_q <= bvc_clean(reg_wdata);
            end
            if (wr_b2) begin
                buck2_q <= bvc_clean(reg_wdata);
            end
            if (wr_go) begin
                go_q <= reg_wdata & `BVC_GO_KEEP_MASK; // Only go-disable is kept.
            end
        end
    end

    // Voltage codes reach the converters only on a commit or with go-disable set.
    always @(posedge core_clk) begin
        if (rst) begin
            buck2_voltage_code <= `BVC_RST_CODE2;
            buck3_voltage_code <= `BVC_RST_CODE3;
        end else if (apply) begin
            buck2_voltage_code <= buck2_q[`BVC_CODE_MSB:0];
            buck3_voltage_code <= buck3_q[`BVC_CODE_MSB:0];
        end
    end

    assign buck2_pulse_skip_enable = buck2_q[`BVC_PSKIP_BIT];
    assign buck3_pulse_skip_enable = buck3_q[`BVC_PSKIP_BIT];
    assign buck3_forced_pwm        = ~buck3_q[`BVC_PSKIP_BIT];

    bvc_blank_timer #(
        .BLANK_CYC (BLANK_CYC)
    ) u_blank (
        .core_clk  (core_clk),
        .rst       (rst),
        .restart   (wr_b3),
        .blank_q   (buck3_blanking)
    );

    assign buck3_ov_flag = buck3_ov_raw && !buck3_blanking;
    assign buck3_uv_flag = buck3_uv_raw && !buck3_blanking;

    // Read data; reserved bit is stored as zero so reads return zero there.
    always @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            case (reg_addr)
                `BVC_ADDR_BUCK2: reg_rdata <= buck2_q;
                `BVC_ADDR_BUCK3: reg_rdata <= buck3_q;
                `BVC_ADDR_GO:    reg_rdata <= go_q;
                default:         reg_rdata <= `BVC_RST_GO;
            endcase
        end
    end
endmodule // bvc_regs

// file: bvc_regs_assertions.sv
`timescale 1ns/1ps
module bvc_regs_chk (
    // Observed design ports.
    input wire       core_clk, rst, reg_wr, unlock_ok, reg_wr_refused,
    input wire [7:0] reg_addr, reg_wdata, reg_rdata,
    input wire       buck3_ov_raw, buck3_uv_raw, buck3_ov_flag, buck3_uv_flag,
    input wire       buck3_blanking, buck3_forced_pwm, buck3_pulse_skip_enable,
    input wire       voltage_change_go_disable,
    input wire [5:0] buck3_voltage_code
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    pwm_force_a: assert property (buck3_forced_pwm == !buck3_pulse_skip_enable)
        else $error("forced pwm not inverse of pulse skip");
    ov_blank_a: assert property (buck3_ov_flag == (buck3_ov_raw && !buck3_blanking))
        else $error("ov flag not blanked");
    uv_blank_a: assert property (buck3_uv_flag == (buck3_uv_raw && !buck3_blanking))
        else $error("uv flag not blanked");
    refuse_flag_a: assert property (reg_wr && !unlock_ok && (reg_addr == 8'h17 || reg_addr == 8'h18)
        |-> reg_wr_refused) else $error("locked write not refused");
    blank_start_a: assert property (reg_wr && unlock_ok && reg_addr == 8'h18 |=> buck3_blanking
        [*8]) else $error("blanking did not start");
    skip_write_a: assert property (reg_wr && unlock_ok && reg_addr == 8'h18
        |=> buck3_pulse_skip_enable == $past(reg_wdata[7])) else $error("skip bit not written");
    code_hold_a: assert property (!voltage_change_go_disable && !(reg_wr && reg_addr == 8'h1A)
        |=> $stable(buck3_voltage_code)) else $error("code changed without go");
    rsvd_zero_a: assert property ($past(reg_addr) == 8'h18 |-> !reg_rdata[6])
        else $error("reserved bit reads one");
endmodule // bvc_regs_chk

// file: bvc_host_model.sv
`timescale 1ns/1ps
module bvc_host_model (
    // Register port seen by the host.
    input  wire       core_clk,
    output reg        reg_wr,
    output reg  [7:0] reg_addr,
    output reg  [7:0] reg_wdata,
    input  wire [7:0] reg_rdata
);
    initial begin
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // One-cycle write strobe; the data line is scrambled once released.
    task wr(input [7:0] a, input [7:0] d);
        @(posedge core_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge core_clk) {reg_wr, reg_wdata} <= {1'b0, ~d};
    endtask
    // Read data is registered, so it is taken two edges after the address.
    task rd(input [7:0] a, output [7:0] d);
        @(posedge core_clk) reg_addr <= a;
        repeat (2) @(posedge core_clk);
        #1 d = reg_rdata;
    endtask
endmodule // bvc_host_model

// file: bvc_regs_tb.sv
`timescale 1ns/1ps
module bvc_regs_tb;
    reg        core_clk = 1'b0, rst = 1'b1, unlock_ok = 1'b0, strap = 1'b1, ov = 1'b0;
    wire       wr, refused, sk2, sk3, pwm, ovf, uvf, blank, gdis;
    wire [7:0] addr, wdata, rdata;
    wire [5:0] code2, code3;
    reg  [7:0] d;
    integer    error_cnt = 0, checked = 0, n;
    bvc_host_model host_u (.core_clk, .reg_wr(wr), .reg_addr(addr), .reg_wdata(wdata),
        .reg_rdata(rdata));
    bvc_regs #(.BLANK_CYC(21'd20)) dut_u (.core_clk, .rst, .reg_wr(wr), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata), .reg_wr_refused(refused), .unlock_ok,
        .default_select_resistor(strap), .buck3_ov_raw(ov), .buck3_uv_raw(ov),
        .buck2_voltage_code(code2), .buck3_voltage_code(code3), .buck2_pulse_skip_enable(sk2),
        .buck3_pulse_skip_enable(sk3), .buck3_forced_pwm(pwm), .buck3_ov_flag(ovf),
        .buck3_uv_flag(uvf), .buck3_blanking(blank), .voltage_change_go_disable(gdis));
    // Compares one value and counts it.
    task chk(input [15:0] got, input [15:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    // Main sequence of register tests.
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        host_u.rd(8'h17, d); chk(d, 8'h99);
        host_u.rd(8'h18, d); chk(d, 8'h8C);
        chk({code2, code3[3:0]}, {6'h19, 4'hC});
        host_u.wr(8'h18, 8'h00); host_u.rd(8'h18, d); chk(d, 8'h8C);
        $display("reset and lock test done");
        unlock_ok <= 1'b1;
        ov <= 1'b1;
        host_u.wr(8'h18, 8'h45);
        #1 n = 0;
        chk({ovf, uvf, pwm, 2'b00, code3[2:0]}, 8'h24);
        while (blank === 1'b1 && n < 100) begin
            @(posedge core_clk) #1 n = n + 1;
        end
        chk(n, 8'd20); chk({ovf, uvf}, 8'h03);
        host_u.rd(8'h18, d); chk(d, 8'h05);
        host_u.wr(8'h1A, 8'h80); host_u.rd(8'h18, d); chk(code3, 6'h05);
        $display("buck3 write and go test done");
        host_u.wr(8'h1A, 8'h01); host_u.wr(8'h17, 8'hFF); host_u.rd(8'h17, d);
        chk({d, gdis, sk2, code2}, {8'hBF, 2'b11, 6'h3F});
        $display("buck2 go-disable test done");
        give_verdict;
    end
endmodule // bvc_regs_tb
bind bvc_regs bvc_regs_chk chk_u (.core_clk, .rst, .reg_wr, .unlock_ok, .reg_wr_refused,
    .reg_addr, .reg_wdata, .reg_rdata, .buck3_ov_raw, .buck3_uv_raw, .buck3_ov_flag,
    .buck3_uv_flag, .buck3_blanking, .buck3_forced_pwm, .buck3_pulse_skip_enable,
    .voltage_change_go_disable, .buck3_voltage_code);
